// ==== hw/acc_pkg.sv ====
// Package of constants and types for the core calibration controller
package acc_pkg;
    // ------------------------------------------------------------
    // Register byte offsets (printed offsets are indices)
    // ------------------------------------------------------------
    localparam logic [7:0] ACC_IDX_SRC_DLY    = 8'h9a;
    localparam logic [7:0] ACC_IDX_MUX_DLY    = 8'h9b;
    localparam logic [7:0] ACC_IDX_CTRL       = 8'h90;
    localparam logic [7:0] ACC_IDX_STATUS     = 8'h91;
    localparam logic [7:0] ACC_IDX_VARIANT    = 8'h92;
    localparam logic [7:0] ACC_IDX_TRIM_BASE  = 8'ha0;
    localparam int         ACC_ADDR_W         = 10;
    localparam int         ACC_NUM_CORES      = 6;
    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int ACC_CTRL_SRC_SEL_BIT  = 0;
    localparam int ACC_CTRL_SW_TRIG_BIT  = 1;
    localparam int ACC_CTRL_BG_EN_BIT    = 2;
    localparam int ACC_CTRL_FG_OS_BIT    = 3;
    localparam int ACC_CTRL_BG_OS_BIT    = 4;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  ACC_CTRL_RST      = 8'h00;
    localparam logic [7:0]  ACC_SRC_DLY_RST   = 8'h00;
    localparam logic [7:0]  ACC_MUX_DLY_RST   = 8'h00;
    localparam logic [1:0]  ACC_VARIANT_RST   = 2'h0;
    localparam logic [11:0] ACC_MID_CODE      = 12'h000;
    // ------------------------------------------------------------
    // Timing in cycles
    // ------------------------------------------------------------
    localparam int ACC_CAL_CYCLES = 64;
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ACC_VAR_QUAD,
        ACC_VAR_DUAL,
        ACC_VAR_SINGLE
    } acc_variant_e;
    typedef enum logic [2:0] {
        ACC_ST_IDLE,
        ACC_ST_FG_CAL,
        ACC_ST_BG_CAL,
        ACC_ST_BG_SWAP
    } acc_state_e;
endpackage : acc_pkg

// ==== hw/acc_cal_engine.sv ====
// Calibration engine shared by the active cores: linearity, gain and offset steps
`timescale 1ns/1ps
module acc_cal_engine
    import acc_pkg::*;
#(
    parameter int CYCLES = acc_pkg::ACC_CAL_CYCLES
) (
    input  wire logic ref_clk_in,
    input  wire logic rst_in,
    input  wire logic clk_en_in,
    input  wire logic start_in,
    input  wire logic with_offset_in,
    output logic      busy_out,
    output logic      done_out,
    output logic [1:0] step_out
);
    // ------------------------------------------------------------
    // Step sequencer
    // ------------------------------------------------------------
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] cnt_q, cnt_d;
    logic [1:0]    step_q, step_d;
    logic          busy_q, busy_d;
    logic          done_q, done_d;

    always_comb begin
        cnt_d  = cnt_q;
        step_d = step_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (!busy_q) begin
            if (start_in) begin
                busy_d = 1'b1;
                step_d = 2'd0;
                cnt_d  = CW'(CYCLES - 1);
            end
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - CW'(1);
        end else if (step_q == 2'd2 || (step_q == 2'd1 && !with_offset_in)) begin
            // Linearity, gain, then offset (only with an offset bit set) against internal reference
            busy_d = 1'b0;
            done_d = 1'b1;
        end else begin
            step_d = step_q + 2'd1;
            cnt_d  = CW'(CYCLES - 1);
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q  <= '0;
            step_q <= 2'd0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else if (clk_en_in) begin
            cnt_q  <= cnt_d;
            step_q <= step_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign busy_out = busy_q;
    assign done_out = done_q;
    assign step_out = step_q;
endmodule : acc_cal_engine

// ==== hw/acc_top.sv ====
// Core calibration controller with Avalon-MM register slave
//
// Contract
// - Foreground calibration forces every output sample to mid-code until it ends.
// - In foreground mode cores 0, 1, 4 and 5 sample inputs A, B, C and D.
// - On the quad variant spare 2 rotates with cores 0/1 and spare 3 with cores 4/5.
// - On the dual variant cores 0 and 1 share spare core 2.
// - On the single variant core 0 is paired with spare core 2.
// - Each pass calibrates linearity and gain, plus offset when either offset enable bit is set, against an internal reference.
// - Foreground calibration runs after reset and the host waits for it before configuring.
// - The trigger comes from the pin or the software bit, picked by the source select bit; a pin trigger only ever starts foreground.
// - Background mode keeps delivering samples without gaps.
// - Background rotation runs continuously, each freshly calibrated core replacing the next.
// - Only one core is calibrated at any time in background rotation.
// - Trim registers reset to factory values that software reads and may overwrite.
`timescale 1ns/1ps
module acc_top
    import acc_pkg::*;
#(
    parameter int                SAMPLE_W = 12,
    parameter int                CAL_CYCLES = acc_pkg::ACC_CAL_CYCLES,
    parameter logic [6*8-1:0]    FACTORY_TRIM = 48'h808080808080
) (
    input  wire logic                         ref_clk_in,
    input  wire logic                         rst_in,
    input  wire logic                         clk_en_in,
    input  wire logic [acc_pkg::ACC_ADDR_W-1:0] avs_address_in,
    input  wire logic                         avs_read_in,
    input  wire logic                         avs_write_in,
    input  wire logic [31:0]                  avs_writedata_in,
    input  wire logic [3:0]                   avs_byteenable_in,
    output logic [31:0]                       avs_readdata_out,
    output logic                              avs_waitrequest_out,
    output logic [1:0]                        avs_response_out,
    input  wire logic                         cal_trigger_pin_in,
    input  wire logic [6*SAMPLE_W-1:0]        core_sample_in,
    output logic [SAMPLE_W-1:0]               analog_input_a_out,
    output logic [SAMPLE_W-1:0]               analog_input_b_out,
    output logic [SAMPLE_W-1:0]               analog_input_c_out,
    output logic [SAMPLE_W-1:0]               analog_input_d_out,
    output logic [5:0]                        core_cal_active_out,
    output logic [5:0]                        core_online_out,
    output logic [7:0]                        core_source_switch_delay_out,
    output logic [7:0]                        swap_mux_select_delay_out,
    output logic [6*8-1:0]                    trim_out
);
    import acc_pkg::*;

    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    logic [7:0]   ctrl_q, ctrl_d;
    logic [7:0]   src_dly_q, src_dly_d;
    logic [7:0]   mux_dly_q, mux_dly_d;
    logic [1:0]   variant_q, variant_d;
    logic [7:0]   trim_q [ACC_NUM_CORES];
    logic [7:0]   trim_d [ACC_NUM_CORES];
    logic [31:0]  rdata_q, rdata_d;
    logic [1:0]   resp_q, resp_d;
    logic         ack_q, ack_d;
    logic         fg_done_q, fg_done_d;
    acc_state_e   st_q, st_d;
    logic [2:0]   cal_core_q, cal_core_d;
    logic [5:0]   online_q, online_d;
    logic [5:0]   active_q, active_d;
    logic [2:0]   slot_q, slot_d;
    logic         boot_q;
    logic [7:0]   swap_cnt_q, swap_cnt_d;
    logic         pin_s1_q, pin_s2_q, pin_s3_q, pin_lvl_q, pin_lvl_d;
    logic         trig_prev_q, trig_prev_d;
    logic [SAMPLE_W-1:0] out_q [4];
    logic [SAMPLE_W-1:0] out_d [4];
    logic         eng_start, eng_busy, eng_done;
    logic         trig_lvl, trig_rise, bus_req;
    logic [7:0]   widx;

    // Merges write-data byte lane 0 into a register when byteenable bit 0 is set
    function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [31:0] wd,
                                              input logic [3:0] be);
        merge_byte = be[0] ? wd[7:0] : old;
    endfunction : merge_byte

    // Next core of a spare's rotation group
    function automatic logic [2:0] next_core(input logic [1:0] var_sel, input logic [2:0] core);
        unique case (core)
            3'd0:    next_core = (var_sel == ACC_VAR_SINGLE) ? 3'd2 : 3'd1;
            3'd1:    next_core = 3'd2;
            3'd2:    next_core = 3'd0;
            3'd3:    next_core = 3'd4;
            3'd4:    next_core = 3'd5;
            default: next_core = 3'd3;
        endcase
    endfunction : next_core

    // ------------------------------------------------------------
    // Trigger pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
        end else if (clk_en_in) begin
            pin_s1_q <= cal_trigger_pin_in;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    always_comb begin
        pin_lvl_d = (pin_s2_q == pin_s3_q) ? pin_s3_q : pin_lvl_q;
        trig_lvl  = ctrl_q[ACC_CTRL_SRC_SEL_BIT] ? pin_lvl_q
                                                 : ctrl_q[ACC_CTRL_SW_TRIG_BIT];
        trig_prev_d = trig_lvl;
        trig_rise   = trig_lvl && !trig_prev_q;
        bus_req     = avs_read_in || avs_write_in;
        widx        = avs_address_in[9:2];
    end

    // ------------------------------------------------------------
    // Calibration sequencer
    // ------------------------------------------------------------
    acc_cal_engine #(
        .CYCLES (CAL_CYCLES)
    ) u_engine (
        .ref_clk_in     (ref_clk_in),
        .rst_in         (rst_in),
        .clk_en_in      (clk_en_in),
        .start_in       (eng_start),
        .with_offset_in (ctrl_q[ACC_CTRL_FG_OS_BIT] | ctrl_q[ACC_CTRL_BG_OS_BIT]),
        .busy_out       (eng_busy),
        .done_out       (eng_done),
        .step_out       ()
    );

    always_comb begin
        st_d       = st_q;
        cal_core_d = cal_core_q;
        online_d   = online_q;
        active_d   = active_q;
        slot_d     = slot_q;
        swap_cnt_d = swap_cnt_q;
        fg_done_d  = fg_done_q;
        eng_start  = 1'b0;
        unique case (st_q)
            ACC_ST_IDLE: begin
                if (trig_rise && ctrl_q[ACC_CTRL_BG_EN_BIT]
                    && !ctrl_q[ACC_CTRL_SRC_SEL_BIT]) begin
                    st_d       = ACC_ST_BG_CAL;
                    slot_d     = 3'd3;
                    cal_core_d = 3'd2;
                    online_d   = 6'b110011;
                    active_d   = 6'b000100;
                    eng_start  = 1'b1;
                end else if (trig_rise) begin
                    st_d      = ACC_ST_FG_CAL;
                    fg_done_d = 1'b0;
                    active_d  = 6'b111111;
                    eng_start = 1'b1;
                end
            end
            ACC_ST_FG_CAL: begin
                if (boot_q) eng_start = 1'b1;
                if (eng_done) begin
                    st_d      = ACC_ST_IDLE;
                    fg_done_d = 1'b1;
                    online_d  = 6'b110011;
                    active_d  = 6'b000000;
                end
            end
            ACC_ST_BG_CAL: begin
                if (eng_done) begin
                    st_d       = ACC_ST_BG_SWAP;
                    swap_cnt_d = src_dly_q;
                    active_d   = 6'b000000;
                end
            end
            ACC_ST_BG_SWAP: begin
                // Freshly calibrated core goes online; replaced core is next, except quad calibrates the other group's core first
                if (swap_cnt_q != 8'h00) begin
                    swap_cnt_d = swap_cnt_q - 8'h01;
                end else if (!ctrl_q[ACC_CTRL_BG_EN_BIT]) begin
                    st_d     = ACC_ST_IDLE;
                    online_d = 6'b110011;
                end else begin
                    online_d[cal_core_q] = 1'b1;
                    online_d[next_core(variant_q, cal_core_q)] = 1'b0;
                    // Quad alternates spare groups so spare 3 gets its turn
                    cal_core_d = (variant_q == ACC_VAR_QUAD) ? slot_q
                                                             : next_core(variant_q, cal_core_q);
                    slot_d     = next_core(variant_q, cal_core_q);
                    active_d   = 6'b000000;
                    active_d[cal_core_d] = 1'b1;
                    st_d      = ACC_ST_BG_CAL;
                    eng_start = 1'b1;
                end
            end
            default: st_d = ACC_ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Sample routing
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            out_d[i] = ACC_MID_CODE[SAMPLE_W-1:0];
        end
        if (st_q != ACC_ST_FG_CAL) begin
            // Each channel reads whichever core currently holds it online
            out_d[0] = core_sample_in[0*SAMPLE_W +: SAMPLE_W];
            out_d[1] = core_sample_in[1*SAMPLE_W +: SAMPLE_W];
            out_d[2] = core_sample_in[4*SAMPLE_W +: SAMPLE_W];
            out_d[3] = core_sample_in[5*SAMPLE_W +: SAMPLE_W];
            if (!online_q[0]) out_d[0] = core_sample_in[2*SAMPLE_W +: SAMPLE_W];
            if (!online_q[1]) out_d[1] = core_sample_in[2*SAMPLE_W +: SAMPLE_W];
            if (!online_q[4]) out_d[2] = core_sample_in[3*SAMPLE_W +: SAMPLE_W];
            if (!online_q[5]) out_d[3] = core_sample_in[3*SAMPLE_W +: SAMPLE_W];
        end
    end

    // ------------------------------------------------------------
    // Avalon-MM slave, answers one cycle after the request
    // ------------------------------------------------------------
    always_comb begin
        ctrl_d    = ctrl_q;
        src_dly_d = src_dly_q;
        mux_dly_d = mux_dly_q;
        variant_d = variant_q;
        trim_d    = trim_q;
        rdata_d   = 32'h0000_0000;
        resp_d    = 2'b00;
        ack_d     = bus_req && !ack_q;
        if (bus_req && !ack_q) begin
            unique case (widx)
                ACC_IDX_CTRL:    rdata_d = {24'h0, ctrl_q};
                ACC_IDX_STATUS:  rdata_d = {21'h0, fg_done_q, eng_busy, st_q, 3'h0, cal_core_q};
                ACC_IDX_VARIANT: rdata_d = {30'h0, variant_q};
                ACC_IDX_SRC_DLY: rdata_d = {24'h0, src_dly_q};
                ACC_IDX_MUX_DLY: rdata_d = {24'h0, mux_dly_q};
                default: begin
                    if (widx >= ACC_IDX_TRIM_BASE && widx < ACC_IDX_TRIM_BASE + 8'd6) begin
                        rdata_d = {24'h0, trim_q[3'(widx - ACC_IDX_TRIM_BASE)]};
                    end else begin
                        resp_d = 2'b10;
                    end
                end
            endcase
        end
        // Write lands on the edge at which waitrequest is seen low
        if (avs_write_in && ack_q) begin
            begin
                rdata_d = 32'h0000_0000;
                unique case (widx)
                    ACC_IDX_CTRL:    ctrl_d = merge_byte(ctrl_q, avs_writedata_in,
                                                         avs_byteenable_in);
                    ACC_IDX_VARIANT: variant_d = (avs_byteenable_in[0] &&
                                                  avs_writedata_in[1:0] != 2'd3) ?
                                                 avs_writedata_in[1:0] : variant_q;
                    ACC_IDX_SRC_DLY: src_dly_d = merge_byte(src_dly_q, avs_writedata_in,
                                                            avs_byteenable_in);
                    ACC_IDX_MUX_DLY: mux_dly_d = merge_byte(mux_dly_q, avs_writedata_in,
                                                            avs_byteenable_in);
                    default: begin
                        if (widx >= ACC_IDX_TRIM_BASE && widx < ACC_IDX_TRIM_BASE + 8'd6)
                            trim_d[3'(widx - ACC_IDX_TRIM_BASE)] = merge_byte(
                                trim_q[3'(widx - ACC_IDX_TRIM_BASE)], avs_writedata_in,
                                avs_byteenable_in);
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl_q      <= ACC_CTRL_RST;
            src_dly_q   <= ACC_SRC_DLY_RST;
            mux_dly_q   <= ACC_MUX_DLY_RST;
            variant_q   <= ACC_VARIANT_RST;
            for (int i = 0; i < ACC_NUM_CORES; i++) begin
                trim_q[i] <= FACTORY_TRIM[i*8 +: 8];
            end
            rdata_q     <= 32'h0000_0000;
            resp_q      <= 2'b00;
            ack_q       <= 1'b0;
            fg_done_q   <= 1'b0;
            // Power-up pass starts straight out of reset
            st_q        <= ACC_ST_FG_CAL;
            cal_core_q  <= 3'd0;
            online_q    <= 6'b110011;
            active_q    <= 6'b111111;
            slot_q      <= 3'd0;
            swap_cnt_q  <= 8'h00;
            pin_lvl_q   <= 1'b0;
            trig_prev_q <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                out_q[i] <= ACC_MID_CODE[SAMPLE_W-1:0];
            end
        end else if (clk_en_in) begin
            ctrl_q      <= ctrl_d;
            src_dly_q   <= src_dly_d;
            mux_dly_q   <= mux_dly_d;
            variant_q   <= variant_d;
            trim_q      <= trim_d;
            rdata_q     <= rdata_d;
            resp_q      <= resp_d;
            ack_q       <= ack_d;
            fg_done_q   <= fg_done_d;
            st_q        <= st_d;
            cal_core_q  <= cal_core_d;
            online_q    <= online_d;
            active_q    <= active_d;
            slot_q      <= slot_d;
            swap_cnt_q  <= swap_cnt_d;
            pin_lvl_q   <= pin_lvl_d;
            trig_prev_q <= trig_prev_d;
            out_q       <= out_d;
        end
    end

    // Engine start after reset: kick once in the first enabled cycle after reset, in FG state
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) boot_q <= 1'b1;
        else if (clk_en_in) boot_q <= 1'b0;
    end

    assign avs_readdata_out             = rdata_q;
    assign avs_waitrequest_out          = !ack_q;
    assign avs_response_out             = resp_q;
    assign analog_input_a_out           = out_q[0];
    assign analog_input_b_out           = out_q[1];
    assign analog_input_c_out           = out_q[2];
    assign analog_input_d_out           = out_q[3];
    assign core_cal_active_out          = active_q;
    assign core_online_out              = online_q;
    assign core_source_switch_delay_out = src_dly_q;
    assign swap_mux_select_delay_out    = mux_dly_q;
    always_comb begin
        for (int i = 0; i < ACC_NUM_CORES; i++) trim_out[i*8 +: 8] = trim_q[i];
    end
endmodule : acc_top

// ==== tb/acc_top_chk.sv ====
// Assertion checker for the core calibration controller ports
`timescale 1ns/1ps
module acc_top_chk
    import acc_pkg::*;
#(
    parameter logic [47:0] FACTORY_TRIM = 48'h808080808080
) (
    input wire logic                  ref_clk_in,
    input wire logic                  rst_in,
    input wire logic [ACC_ADDR_W-1:0] avs_address_in,
    input wire logic                  avs_read_in,
    input wire logic                  avs_write_in,
    input wire logic [31:0]           avs_writedata_in,
    input wire logic                  avs_waitrequest_out,
    input wire logic [1:0]            avs_response_out,
    input wire logic [11:0]           analog_input_a_out,
    input wire logic [5:0]            core_cal_active_out,
    input wire logic [5:0]            core_online_out,
    input wire logic [7:0]            core_source_switch_delay_out,
    input wire logic [7:0]            swap_mux_select_delay_out,
    input wire logic [47:0]           trim_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    sequence taken(logic [7:0] idx);
        avs_write_in && !avs_waitrequest_out && avs_address_in[9:2] == idx;
    endsequence
    reset_map_a: assert property ($fell(rst_in) |-> core_online_out == 6'h33)
        else $error("online cores wrong after reset");
    trim_reset_a: assert property ($fell(rst_in) |-> trim_out == FACTORY_TRIM)
        else $error("trim not factory value after reset");
    mid_code_a: assert property (core_cal_active_out == 6'h3f
        && $past(core_cal_active_out) == 6'h3f |-> analog_input_a_out == 12'h000)
        else $error("sample not mid-code in foreground pass");
    one_core_a: assert property (core_cal_active_out != 6'h3f
        |-> $onehot0(core_cal_active_out)) else $error("several cores calibrating");
    online_cnt_a: assert property ($countones(core_online_out) >= 4)
        else $error("fewer than four cores serving");
    wait_one_a: assert property ($rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out)
        else $error("no wait state on new request");
    wait_end_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out) else $error("wait state too long");
    unmapped_rd_a: assert property (avs_read_in && !avs_waitrequest_out
        && avs_address_in[9:2] == 8'h00 |-> avs_response_out == 2'b10)
        else $error("unmapped read not flagged");
    src_dly_a: assert property (taken(ACC_IDX_SRC_DLY)
        |=> core_source_switch_delay_out == $past(avs_writedata_in[7:0]))
        else $error("switch delay not written");
    mux_dly_a: assert property (taken(ACC_IDX_MUX_DLY)
        |=> swap_mux_select_delay_out == $past(avs_writedata_in[7:0]))
        else $error("mux delay not written");
endmodule : acc_top_chk
bind acc_top acc_top_chk #(.FACTORY_TRIM(FACTORY_TRIM)) acc_top_chk_i (.*);

// ==== tb/acc_host_model.sv ====
// Host-side model: calibration trigger pin and raw core samples
`timescale 1ns/1ps
module acc_host_model (
    input  wire logic        ref_clk_in,
    input  wire logic        trig_req_in,
    output logic             cal_trigger_pin_out,
    output logic [71:0]      core_sample_out
);
    // Distinct nonzero value per core so every mapping is visible
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            core_sample_out[i*12+:12] = 12'h100 + 12'(i);
        end
    end
    always_ff @(posedge ref_clk_in) begin
        cal_trigger_pin_out <= trig_req_in;
    end
endmodule : acc_host_model

// ==== tb/adc_core_calibration_control_test.sv ====
// Self-checking testbench for the core calibration controller
`timescale 1ns/1ps
module adc_core_calibration_control_test;
    import acc_pkg::*;
    logic        ref_clk_in = 1'b0;
    logic        rst_in     = 1'b1;
    logic [9:0]  address    = '0;
    logic        rd         = 1'b0;
    logic        wr         = 1'b0;
    logic [31:0] wdata      = '0;
    logic        trig_req   = 1'b0;
    logic        pin, waitreq;
    logic [71:0] samples;
    logic [31:0] readdata, rdata;
    logic [1:0]  response, rresp;
    logic [11:0] a_out, b_out, c_out, d_out;
    logic [5:0]  active, online;
    logic [7:0]  src_dly, mux_dly;
    logic [47:0] trim;
    int          fails = 0;
    int          num_checks = 0;
    acc_host_model acc_host_model_i (.ref_clk_in(ref_clk_in), .trig_req_in(trig_req),
        .cal_trigger_pin_out(pin), .core_sample_out(samples));
    acc_top #(.CAL_CYCLES(4)) acc_top_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .clk_en_in(1'b1), .avs_address_in(address), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wdata), .avs_byteenable_in(4'hf), .avs_readdata_out(readdata),
        .avs_waitrequest_out(waitreq), .avs_response_out(response),
        .cal_trigger_pin_in(pin), .core_sample_in(samples), .analog_input_a_out(a_out),
        .analog_input_b_out(b_out), .analog_input_c_out(c_out), .analog_input_d_out(d_out),
        .core_cal_active_out(active), .core_online_out(online),
        .core_source_switch_delay_out(src_dly), .swap_mux_select_delay_out(mux_dly),
        .trim_out(trim));
    initial begin
        forever #2.5 ref_clk_in = ~ref_clk_in;
    end
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test
    // Holds the request until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk_in);
        address <= {idx, 2'b00};
        wdata <= {24'h0, wd};
        wr <= w;
        rd <= !w;
        do @(posedge ref_clk_in); while (waitreq !== 1'b0 && ++n < 20);
        if (waitreq !== 1'b0) fails++;
        rdata = readdata;
        rresp = response;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic t_fg(input logic use_pin);
        int n;
        n = 0;
        if (use_pin) begin
            bus(1'b1, ACC_IDX_CTRL, 8'h01);
            trig_req <= 1'b1;
            repeat (8) @(posedge ref_clk_in);
            chk(active, 6'h3f);
            chk(a_out, ACC_MID_CODE);
            trig_req <= 1'b0;
        end else begin
            while (active === 6'h3f) @(posedge ref_clk_in);
            bus(1'b1, ACC_IDX_CTRL, 8'h00);
            bus(1'b1, ACC_IDX_CTRL, 8'h02);
            repeat (2) @(posedge ref_clk_in);
            chk(active, 6'h3f);
        end
        while (active === 6'h3f && n < 300) begin
            @(posedge ref_clk_in);
            n++;
        end
        repeat (2) @(posedge ref_clk_in);
        bus(1'b0, ACC_IDX_STATUS, 8'h00);
        chk(rdata[10], 1'b1);
        chk({a_out, b_out, c_out, d_out}, 48'h100_101_104_105);
    endtask : t_fg
    task automatic t_regs();
        bus(1'b1, ACC_IDX_SRC_DLY, 8'h1f);
        bus(1'b1, ACC_IDX_MUX_DLY, 8'h1e);
        bus(1'b0, ACC_IDX_SRC_DLY, 8'h00);
        chk({rdata, src_dly, mux_dly}, 48'h1f_1f1e);
        bus(1'b0, 8'h00, 8'h00);
        chk({rresp, rdata}, 34'h200000000);
        bus(1'b0, ACC_IDX_TRIM_BASE, 8'h00);
        chk(rdata, 32'h80);
        bus(1'b1, ACC_IDX_TRIM_BASE, 8'h5a);
        bus(1'b0, ACC_IDX_TRIM_BASE, 8'h00);
        chk({rdata[7:0], trim[7:0]}, 16'h5a5a);
    endtask : t_regs
    task automatic t_bg();
        logic [5:0] seen_cal;
        logic [5:0] seen_on;
        seen_cal = '0;
        seen_on = '0;
        bus(1'b1, ACC_IDX_CTRL, 8'h04);
        bus(1'b1, ACC_IDX_CTRL, 8'h06);
        repeat (800) begin
            @(posedge ref_clk_in);
            seen_cal |= active;
            seen_on |= online;
            chk($countones(active) <= 1, 1'b1);
            chk(a_out === 12'h000, 1'b0);
        end
        chk(seen_cal, 6'h3f);
        chk(seen_on[3:2], 2'b11);
    endtask : t_bg
    initial begin
        #100us;
        fails++;
        finish_test();
    end
    initial begin
        repeat (20) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        @(posedge ref_clk_in);
        chk({online, trim, a_out}, {6'h33, 48'h808080808080, ACC_MID_CODE});
        t_fg(1'b0);
        t_regs();
        t_fg(1'b1);
        t_bg();
        finish_test();
    end
endmodule : adc_core_calibration_control_test
